// ### core/wwdt_defs.vh
// Register map, field positions, encodings and timing counts of the windowed watchdog.
`ifndef WWDT_DEFS_VH
`define WWDT_DEFS_VH

// Register indexes as printed; the byte address is four times the index.
`define WWDT_IDX_SETUP 2'h0
`define WWDT_IDX_STATE 2'h1

// Setup register fields.
`define WWDT_CLOSED_HI 7
`define WWDT_CLOSED_LO 4
`define WWDT_TIMEOUT_HI 3
`define WWDT_TIMEOUT_LO 0

// State register fields.
`define WWDT_LOCK_BIT 7
`define WWDT_PENDING_BIT 0

// Reset values.
`define WWDT_SETUP_RESET 8'h00
`define WWDT_LOCK_RESET 1'b0

// Duration codes.
`define WWDT_CODE_OFF 4'h0
`define WWDT_CODE_MIN 4'h1
`define WWDT_CODE_MAX 4'hB
`define WWDT_CODE_SHIFT 4'h2

// Slow tick counter width, enough for 8192 ticks.
`define WWDT_COUNT_W 14

// Unlock span after the key is written, in CPU instructions, one per clock here.
`define WWDT_GUARD_SPAN 3'h4

`endif

// ### core/wwdt_windowed_watchdog.v
// Windowed watchdog with guarded setup, lock, and slow-tick counting domain.
`timescale 1ns/10ps
`default_nettype none
`include "wwdt_defs.vh"

module wwdt_windowed_watchdog (
    input wire clk,
    input wire rst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire slowTickPin,
    input wire restartCmd,
    input wire guardKeyWritten,
    input wire debugHalt,
    input wire debugMode,
    input wire fuseLoad,
    input wire [7:0] fuseConfig,
    output reg systemReset,
    output wire crossingPending
);

    localparam PH_OPEN = 1'b0;
    localparam PH_CLOSED = 1'b1;

    reg [7:0] setup;
    reg [7:0] applied;
    reg lockBit;
    reg [2:0] guardCount;
    reg tickS1;
    reg tickS2;
    reg tickS3;
    reg cfgToggle;
    reg cfgS1;
    reg cfgS2;
    reg cfgS3;
    reg rstToggle;
    reg rstS1;
    reg rstS2;
    reg rstS3;
    reg phase;
    reg [`WWDT_COUNT_W-1:0] count;

    // Next values of the counting state, worked out combinationally.
    reg next_phase;
    reg [`WWDT_COUNT_W-1:0] next_count;
    reg next_systemReset;

    wire tickEn;
    wire guardOpen;
    wire busReq;
    wire [1:0] regIdx;
    wire wrSetup;
    wire wrState;
    wire restartBusy;
    wire restartEvent;
    wire cfgEvent;
    wire [3:0] closedCode;
    wire [3:0] timeoutCode;
    wire [`WWDT_COUNT_W:0] closedTicks;
    wire [`WWDT_COUNT_W:0] timeoutTicks;
    wire [`WWDT_COUNT_W:0] limit;
    wire [`WWDT_COUNT_W:0] countNext;

    // Ticks for a duration code; reserved and off codes give zero.
    function [`WWDT_COUNT_W:0] codeTicks;
        input [3:0] code;
        begin
            if (code >= `WWDT_CODE_MIN && code <= `WWDT_CODE_MAX) begin
                codeTicks = {{`WWDT_COUNT_W{1'b0}}, 1'b1} << (code + `WWDT_CODE_SHIFT);
            end else begin
                codeTicks = {(`WWDT_COUNT_W+1){1'b0}};
            end
        end
    endfunction

    // True when a duration is off or reserved, so that span is not in use.
    function ticksZero;
        input [`WWDT_COUNT_W:0] ticks;
        begin
            ticksZero = (ticks == {(`WWDT_COUNT_W+1){1'b0}});
        end
    endfunction

    // The tick pin is foreign to clk, so only the second and third stages feed the edge detector.
    assign tickEn = tickS2 & ~tickS3;
    assign guardOpen = (guardCount != 3'h0);
    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign regIdx = wb_adr_i[3:2];
    assign wrSetup = busReq & wb_we_i & wb_sel_i[0] & (regIdx == `WWDT_IDX_SETUP);
    assign wrState = busReq & wb_we_i & wb_sel_i[0] & (regIdx == `WWDT_IDX_STATE);
    assign crossingPending = (cfgToggle != cfgS3);
    assign restartBusy = (rstToggle != rstS3);
    assign restartEvent = tickEn & (rstS2 != rstS3);
    assign cfgEvent = tickEn & (cfgS2 != cfgS3);
    assign closedCode = applied[`WWDT_CLOSED_HI:`WWDT_CLOSED_LO];
    assign timeoutCode = applied[`WWDT_TIMEOUT_HI:`WWDT_TIMEOUT_LO];
    assign closedTicks = codeTicks(closedCode);
    assign timeoutTicks = codeTicks(timeoutCode);
    assign limit = (phase == PH_CLOSED) ? closedTicks : timeoutTicks;
    assign countNext = {1'b0, count} + {{`WWDT_COUNT_W{1'b0}}, 1'b1};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq;
            if (busReq) begin
                case (regIdx)
                    `WWDT_IDX_SETUP: begin
                        wb_dat_o <= {24'h000000, setup};
                    end
                    `WWDT_IDX_STATE: begin
                        wb_dat_o <= {24'h000000, lockBit, 6'h00, crossingPending};
                    end
                    default: begin
                        wb_dat_o <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // Guard window: the key pulse opens it for a fixed number of clk cycles.
    // A new key while the window is open simply restarts the span.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            guardCount <= 3'h0;
        end else begin
            if (guardKeyWritten) begin
                guardCount <= `WWDT_GUARD_SPAN;
            end else if (guardOpen) begin
                guardCount <= guardCount - 3'h1;
            end
        end
    end

    // Setup copy on the CPU side; every accepted write launches one crossing.
    // The fuse load bypasses the crossing because the tick may not run yet at boot.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup <= `WWDT_SETUP_RESET;
            cfgToggle <= 1'b0;
        end else begin
            if (fuseLoad) begin
                setup <= fuseConfig;
            end else begin
                // A write while the previous one still crosses would tear the applied copy.
                if (wrSetup && guardOpen && !lockBit && !crossingPending) begin
                    setup <= wb_dat_i[7:0];
                    cfgToggle <= ~cfgToggle;
                end
            end
        end
    end

    // Lock: software may only set it; clearing needs debug mode.
    // It lives in the clk domain, so no crossing delays its effect on writes.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockBit <= `WWDT_LOCK_RESET;
        end else begin
            if (fuseLoad) begin
                lockBit <= (fuseConfig[`WWDT_TIMEOUT_HI:`WWDT_TIMEOUT_LO] != `WWDT_CODE_OFF);
            end else begin
                if (wrState && guardOpen) begin
                    if (wb_dat_i[`WWDT_LOCK_BIT]) begin
                        lockBit <= 1'b1;
                    end else if (debugMode) begin
                        lockBit <= 1'b0;
                    end
                end
            end
        end
    end

    // Restart request: a toggle, so a one-cycle pulse survives the slow sampling.
    // Pulses that arrive while the toggle is still crossing are dropped on purpose.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstToggle <= 1'b0;
        end else begin
            if (restartCmd && !restartBusy) begin
                rstToggle <= ~rstToggle;
            end
        end
    end

    // Tick pin synchronizer and edge history.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tickS1 <= 1'b0;
            tickS2 <= 1'b0;
            tickS3 <= 1'b0;
        end else begin
            tickS1 <= slowTickPin;
            tickS2 <= tickS1;
            tickS3 <= tickS2;
        end
    end

    // Slow tick domain stages: they advance only on the tick enable.
    // Stepping on the tick makes both crossings last two to three tick periods.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgS1 <= 1'b0;
            cfgS2 <= 1'b0;
            cfgS3 <= 1'b0;
            rstS1 <= 1'b0;
            rstS2 <= 1'b0;
            rstS3 <= 1'b0;
        end else begin
            if (tickEn) begin
                cfgS1 <= cfgToggle;
                cfgS2 <= cfgS1;
                cfgS3 <= cfgS2;
                rstS1 <= rstToggle;
                rstS2 <= rstS1;
                rstS3 <= rstS2;
            end
        end
    end

    // Applied copy used by the counter; setup is stable while the crossing runs.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied <= `WWDT_SETUP_RESET;
        end else begin
            if (fuseLoad) begin
                applied <= fuseConfig;
            end else if (cfgEvent) begin
                applied <= setup;
            end
        end
    end

    // Next counting state; one tick enable moves it by at most one step.
    // Counting depends only on the tick, the restart crossing, debugHalt and the applied setup, so any sleep state keeps it running.
    always @* begin
        next_count = count;
        next_phase = phase;
        next_systemReset = 1'b0;
        if (tickEn) begin
            if (debugHalt || ticksZero(timeoutTicks)) begin
                next_count = {`WWDT_COUNT_W{1'b0}};
                next_phase = PH_OPEN;
            end else if (ticksZero(closedTicks) && phase == PH_CLOSED) begin
                next_phase = PH_OPEN;
                next_count = {`WWDT_COUNT_W{1'b0}};
            end else if (restartEvent) begin
                next_count = {`WWDT_COUNT_W{1'b0}};
                if (phase == PH_CLOSED) begin
                    next_systemReset = 1'b1;
                    next_phase = PH_OPEN;
                end else if (!ticksZero(closedTicks)) begin
                    next_phase = PH_CLOSED;
                end
            end else if (countNext >= limit) begin
                next_count = {`WWDT_COUNT_W{1'b0}};
                if (phase == PH_CLOSED) begin
                    next_phase = PH_OPEN;
                end else begin
                    next_systemReset = 1'b1;
                end
            end else begin
                next_count = countNext[`WWDT_COUNT_W-1:0];
            end
        end
    end

    // Counting state registers; the reset pulse is registered, never combinational.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_OPEN;
            count <= {`WWDT_COUNT_W{1'b0}};
            systemReset <= 1'b0;
        end else begin
            phase <= next_phase;
            count <= next_count;
            systemReset <= next_systemReset;
        end
    end

endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the windowed watchdog.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic slowTickPin = 1'b0, debugHalt = 1'b0, debugMode = 1'b0, fuseLoad = 1'b0;
    logic reqRst = 1'b0, reqKey = 1'b0, wb_ack_o, systemReset, crossingPending;
    logic restartCmd, guardKeyWritten;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
    logic [7:0] fuseConfig = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    int err_total = 0, n_tests = 0, cycles = 0, nRst = 0, mSetup = 0, mLock = 0, c, t, n0;
    wwdt_windowed_watchdog u_wwdt_windowed_watchdog (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .slowTickPin(slowTickPin), .restartCmd(restartCmd),
        .guardKeyWritten(guardKeyWritten), .debugHalt(debugHalt), .debugMode(debugMode),
        .fuseLoad(fuseLoad), .fuseConfig(fuseConfig), .systemReset(systemReset),
        .crossingPending(crossingPending));
    wwdt_cpu_model u_wwdt_cpu_model (.clk(clk), .reqRst(reqRst), .reqKey(reqKey),
        .restartCmd(restartCmd), .guardKeyWritten(guardKeyWritten));
    always #10 clk = ~clk;
    // The slow tick runs at one eighth of clk so that long timeouts fit the run.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        slowTickPin <= cycles[2];
        nRst <= nRst + int'(systemReset);
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", s, e, g);
            err_total++;
        end
    endtask
    task automatic bus(logic [3:0] a, logic w, logic [7:0] d, logic g);
        int n;
        n = 0;
        if (g) begin
            reqKey <= 1'b1;
            @(posedge clk) reqKey <= 1'b0;
        end
        @(posedge clk) {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 24'h0, d};
        do @(posedge clk); while (wb_ack_o !== 1'b1 && ++n < 20);
        if (n == 20) err_total++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (w && g && a[3:2] == 2'h0 && mLock == 0) mSetup = d;
        if (w && g && a[3:2] == 2'h1) mLock = d[7] || (mLock && !debugMode);
    endtask
    task automatic verify();
        int n;
        n = 0;
        do bus(4'h4, 1'b0, 8'h00, 1'b0); while (q[0] !== 1'b0 && ++n < 50);
        chk("state", {mLock[0], 7'h00}, q);
        bus(4'h0, 1'b0, 8'h00, 1'b0);
        chk("setup", mSetup, q);
    endtask
    task automatic kick();
        @(posedge clk) reqRst <= 1'b1;
        @(posedge clk) reqRst <= 1'b0;
    endtask
    task automatic waitRst(int lim);
        t = 0;
        while (systemReset !== 1'b1 && t < lim) begin
            @(posedge clk);
            t++;
        end
    endtask
    initial begin
        void'($urandom(32'hE4F8411A));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        bus(4'h8, 1'b0, 8'h00, 1'b0);
        chk("hole", 32'h0, q);
        bus(4'h0, 1'b1, 8'h05, 1'b0);
        verify();
        c = 2 + $urandom % 2;
        bus(4'h0, 1'b1, c[7:0], 1'b1);
        verify();
        n0 = nRst;
        repeat (3) begin
            repeat (40) @(posedge clk);
            kick();
        end
        chk("kept", n0, nRst);
        waitRst(400);
        chk("normal", 1, t >= (1 << (c + 5)) + 8 && t <= (1 << (c + 5)) + 48);
        bus(4'h0, 1'b1, 8'h12, 1'b1);
        verify();
        n0 = nRst;
        kick();
        repeat (40) @(posedge clk);
        chk("armed", n0, nRst);
        kick();
        waitRst(40);
        chk("early", 1, t < 40);
        bus(4'h4, 1'b1, 8'h80, 1'b1);
        bus(4'h0, 1'b1, 8'h00, 1'b1);
        bus(4'h4, 1'b1, 8'h00, 1'b1);
        verify();
        debugMode <= 1'b1;
        debugHalt <= 1'b1;
        bus(4'h4, 1'b1, 8'h00, 1'b1);
        verify();
        repeat (16) @(posedge clk);
        n0 = nRst;
        repeat (600) @(posedge clk);
        chk("halt", n0, nRst);
        {debugMode, debugHalt, fuseConfig, fuseLoad} <= {2'h0, 8'h03, 1'b1};
        @(posedge clk) fuseLoad <= 1'b0;
        mSetup = 3;
        mLock = 1;
        verify();
        test_done();
    end
endmodule
`default_nettype wire

// ### tb/wwdt_cpu_model.sv
// CPU-side model that issues restart and unlock-key pulses.
`timescale 1ns/10ps
`default_nettype none
module wwdt_cpu_model (
    input wire logic clk,
    input wire logic reqRst,
    input wire logic reqKey,
    output logic restartCmd,
    output logic guardKeyWritten
);
    // One clean pulse a request; the bench opens its guarded write right after the key.
    always @(posedge clk) begin
        restartCmd <= reqRst;
        guardKeyWritten <= reqKey;
    end
endmodule
`default_nettype wire

// ### tb/wwdt_windowed_watchdog_properties.sv
// Concurrent checks on the watchdog ports.
`timescale 1ns/10ps
`default_nettype none
module wwdt_windowed_watchdog_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic systemReset,
    input wire logic crossingPending
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    rst_pulse_a: assert property (systemReset |=> !systemReset)
        else $error("reset pulse too long");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    hole_read_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[3] |-> ~|wb_dat_o) else $error("hole not zero");
    flag_read_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h1 |-> wb_dat_o[0] == $past(crossingPending))
        else $error("pending bit misread");
    flag_cause_a: assert property ($rose(crossingPending) |-> wb_ack_o && wb_we_i)
        else $error("pending without write");
    // The bound suits the bench's fast tick; a true 1 kHz tick needs a counter instead.
    flag_end_a: assert property ($rose(crossingPending) |-> ##[1:60] !crossingPending)
        else $error("pending stuck");
endmodule
bind wwdt_windowed_watchdog wwdt_windowed_watchdog_properties u_props (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .systemReset(systemReset), .crossingPending(crossingPending));
`default_nettype wire
